/* File: rtl/abe_pkg.sv */
// Summary of operation
// - add literal into work, update C, DC, Z
// - clear one file bit, flags untouched
// - add work and file, update C, DC, Z
// - destination bit 0 to work, 1 to file
// - set one file bit, flags untouched
// - AND literal into work, update Z only
// - AND work with file, update Z only
// - skip next instruction when tested bit is one
// - skip next instruction when tested bit is zero
// - port register read uses pin levels
`default_nettype none
package abe_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int OPC_W = 14;
  localparam int AXI_AW = 6;
  localparam int AXI_DW = 32;

  // instruction field positions
  localparam int F_LSB = 0;
  localparam int F_MSB = 6;
  localparam int D_POS = 7;
  localparam int B_LSB = 7;
  localparam int B_MSB = 9;
  localparam int K_MSB = 7;
  localparam int SUB_LSB = 10;
  localparam int SUB_MSB = 11;
  localparam int OP6_LSB = 8;
  localparam int OP5_LSB = 9;
  localparam int GRP_LSB = 12;
  localparam int NIB_MSB = 3;

  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [4:0] OPC_ADD_LIT = 5'h1f;
  localparam logic [1:0] OPC_BIT_GRP = 2'h1;
  localparam logic [1:0] BITOP_CLEAR = 2'h0;
  localparam logic [1:0] BITOP_SET = 2'h1;
  localparam logic [1:0] BITOP_SKIP_ZERO = 2'h2;
  localparam logic [1:0] BITOP_SKIP_ONE = 2'h3;
  localparam logic DEST_WORK = 1'b0;

  localparam logic [FADDR_W-1:0] PORT_ADDR = 7'h06;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [FADDR_W-1:0] FSEL_RESET = 7'h00;

  localparam logic [AXI_AW-1:0] REG_WORK = 6'h00;
  localparam logic [AXI_AW-1:0] REG_FLAGS = 6'h04;
  localparam logic [AXI_AW-1:0] REG_FSEL = 6'h08;
  localparam logic [AXI_AW-1:0] REG_FDATA = 6'h0c;
  localparam logic [AXI_AW-1:0] REG_STATE = 6'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } abe_flags_s;

  localparam abe_flags_s FLAGS_RESET = 3'h0;

  typedef struct packed {
    logic             valid;
    logic [OPC_W-1:0] word;
  } abe_instr_s;

  typedef enum logic {
    SLOT_EXEC    = 1'b0,
    SLOT_DISCARD = 1'b1
  } abe_slot_e;
endpackage
`default_nettype wire

/* File: rtl/abe_exec_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module abe_exec_unit (
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire abe_pkg::abe_instr_s           instr_in,
  output logic                               instr_ready_out,
  output logic                               retire_out,
  output logic                               discard_out,
  input  wire logic [abe_pkg::DATA_W-1:0]    port_pins_in,
  output logic [abe_pkg::DATA_W-1:0]         port_latch_out,
  output logic [abe_pkg::DATA_W-1:0]         work_out,
  output abe_pkg::abe_flags_s                flags_out,
  input  wire logic [abe_pkg::AXI_AW-1:0]    axi_awaddr_in,
  input  wire logic                          axi_awvalid_in,
  output logic                               axi_awready_out,
  input  wire logic [abe_pkg::AXI_DW-1:0]    axi_wdata_in,
  input  wire logic [abe_pkg::AXI_DW/8-1:0]  axi_wstrb_in,
  input  wire logic                          axi_wvalid_in,
  output logic                               axi_wready_out,
  output logic [1:0]                         axi_bresp_out,
  output logic                               axi_bvalid_out,
  input  wire logic                          axi_bready_in,
  input  wire logic [abe_pkg::AXI_AW-1:0]    axi_araddr_in,
  input  wire logic                          axi_arvalid_in,
  output logic                               axi_arready_out,
  output logic [abe_pkg::AXI_DW-1:0]         axi_rdata_out,
  output logic [1:0]                         axi_rresp_out,
  output logic                               axi_rvalid_out,
  input  wire logic                          axi_rready_in
);
  import abe_pkg::*;

  // pin synchroniser: a change counts once stages two and three agree
  logic [DATA_W-1:0] pin_s1, pin_s2, pin_s3, pin_val, next_pin_val;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_pin
      always_comb begin
        next_pin_val[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s2[gi] : pin_val[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pin_val <= '0;
    end else if (ce_in) begin
      pin_s1  <= port_pins_in;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_val <= next_pin_val;
    end
  end

  // core state
  logic [DATA_W-1:0]  mem [2**FADDR_W];
  logic [DATA_W-1:0]  work, next_work, latch, next_latch;
  abe_flags_s         flags, next_flags;
  abe_slot_e          slot, next_slot;
  logic [FADDR_W-1:0] fsel, next_fsel;
  logic               retire, next_retire, discard, next_discard;
  logic               mem_we;

  // bus state
  logic               aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [AXI_AW-1:0]  aw_addr, next_aw_addr;
  logic [DATA_W-1:0]  w_data, next_w_data;
  logic               w_lane, next_w_lane;
  logic               bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]         bresp, next_bresp, rresp, next_rresp;
  logic [AXI_DW-1:0]  rdata, next_rdata;

  logic [FADDR_W-1:0] f_addr, wr_addr;
  logic [DATA_W-1:0]  src, opnd, k_lit, res, mask, wr_data, peek;
  logic [DATA_W:0]    sum;
  logic [NIB_MSB+1:0] nib_sum;
  logic [BIT_W-1:0]   bsel;
  logic [1:0]         bit_op;
  logic               take, exec, wr_en, wr_go, rd_go;
  logic               is_add_lit, is_and_lit, is_add_f, is_and_f, is_bit;

  assign instr_ready_out = ce_in;
  assign take            = ce_in & instr_in.valid;
  assign exec            = take & (slot == SLOT_EXEC);

  assign f_addr = instr_in.word[F_MSB:F_LSB];
  assign bsel   = instr_in.word[B_MSB:B_LSB];
  assign bit_op = instr_in.word[SUB_MSB:SUB_LSB];
  assign k_lit  = instr_in.word[K_MSB:F_LSB];

  assign is_add_lit = instr_in.word[OPC_W-1:OP5_LSB] == OPC_ADD_LIT;
  assign is_and_lit = instr_in.word[OPC_W-1:OP6_LSB] == OPC_AND_LIT;
  assign is_add_f   = instr_in.word[OPC_W-1:OP6_LSB] == OPC_ADD_FILE;
  assign is_and_f   = instr_in.word[OPC_W-1:OP6_LSB] == OPC_AND_FILE;
  assign is_bit     = instr_in.word[OPC_W-1:GRP_LSB] == OPC_BIT_GRP;

  // the port address reads the pins, so read-modify-write follows them
  assign src  = (f_addr == PORT_ADDR) ? pin_val : mem[f_addr];
  assign peek = (fsel == PORT_ADDR) ? pin_val : mem[fsel];
  assign opnd = (is_add_lit | is_and_lit) ? k_lit : src;
  assign sum  = {1'b0, work} + {1'b0, opnd};
  assign nib_sum = {1'b0, work[NIB_MSB:0]} + {1'b0, opnd[NIB_MSB:0]};
  assign mask = DATA_W'(1) << bsel;

  // bus writes wait while any instruction is taken, so none is lost
  assign wr_go = aw_hold & w_hold & ~bvalid & ~take;

  always_comb begin
    next_work    = work;
    next_flags   = flags;
    next_slot    = slot;
    next_latch   = latch;
    next_fsel    = fsel;
    next_retire  = 1'b0;
    next_discard = 1'b0;
    res          = '0;
    wr_en        = 1'b0;
    wr_addr      = f_addr;
    wr_data      = '0;
    mem_we       = 1'b0;
    if (exec) begin
      next_retire = 1'b1;
      if (is_add_lit | is_add_f) begin
        res          = sum[DATA_W-1:0];
        next_flags.c  = sum[DATA_W];
        next_flags.dc = nib_sum[NIB_MSB+1];
        next_flags.z  = (res == '0);
      end else if (is_and_lit | is_and_f) begin
        res          = work & opnd;
        next_flags.z = (res == '0);
      end
      if (is_add_lit | is_and_lit) begin
        next_work = res;
      end else if (is_add_f | is_and_f) begin
        if (instr_in.word[D_POS] == DEST_WORK) begin
          next_work = res;
        end else begin
          wr_en   = 1'b1;
          wr_data = res;
        end
      end else if (is_bit) begin
        unique case (bit_op)
          BITOP_CLEAR: begin
            wr_en   = 1'b1;
            wr_data = src & ~mask;
          end
          BITOP_SET: begin
            wr_en   = 1'b1;
            wr_data = src | mask;
          end
          BITOP_SKIP_ZERO: begin
            if (!src[bsel]) next_slot = SLOT_DISCARD;
          end
          BITOP_SKIP_ONE: begin
            if (src[bsel]) next_slot = SLOT_DISCARD;
          end
        endcase
      end
    end else if (take) begin
      // the discarded instruction raises discard, not retire, second cycle of the skip
      next_slot    = SLOT_EXEC;
      next_discard = 1'b1;
    end else if (wr_go && w_lane) begin
      unique case (aw_addr[AXI_AW-1:2])
        REG_WORK[AXI_AW-1:2]:  next_work = w_data;
        REG_FLAGS[AXI_AW-1:2]: next_flags = w_data[$bits(abe_flags_s)-1:0];
        REG_FSEL[AXI_AW-1:2]:  next_fsel = w_data[FADDR_W-1:0];
        REG_FDATA[AXI_AW-1:2]: begin
          wr_en   = 1'b1;
          wr_addr = fsel;
          wr_data = w_data;
        end
        default: ;
      endcase
    end
    if (wr_en) begin
      if (wr_addr == PORT_ADDR) next_latch = wr_data;
      else mem_we = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      work    <= WORK_RESET;
      flags   <= FLAGS_RESET;
      slot    <= SLOT_EXEC;
      latch   <= LATCH_RESET;
      fsel    <= FSEL_RESET;
      retire  <= 1'b0;
      discard <= 1'b0;
    end else if (ce_in) begin
      work    <= next_work;
      flags   <= next_flags;
      slot    <= next_slot;
      latch   <= next_latch;
      fsel    <= next_fsel;
      retire  <= next_retire;
      discard <= next_discard;
    end
  end

  // file array has no reset, as in a real register file
  always_ff @(posedge clk_sys_in) begin
    if (ce_in && mem_we) mem[wr_addr] <= wr_data;
  end

  // bus slave
  assign axi_awready_out = ce_in & ~aw_hold & ~bvalid;
  assign axi_wready_out  = ce_in & ~w_hold & ~bvalid;
  assign axi_arready_out = ce_in & ~rvalid;
  assign rd_go           = axi_arvalid_in & axi_arready_out;

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_lane  = w_lane;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (axi_awvalid_in && axi_awready_out) begin
      next_aw_hold = 1'b1;
      next_aw_addr = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out) begin
      next_w_hold = 1'b1;
      next_w_data = axi_wdata_in[DATA_W-1:0];
      next_w_lane = axi_wstrb_in[0];
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr[AXI_AW-1:2] > REG_STATE[AXI_AW-1:2]) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid && axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (axi_araddr_in[AXI_AW-1:2])
        REG_WORK[AXI_AW-1:2]:  next_rdata = AXI_DW'(work);
        REG_FLAGS[AXI_AW-1:2]: next_rdata = AXI_DW'(flags);
        REG_FSEL[AXI_AW-1:2]:  next_rdata = AXI_DW'(fsel);
        REG_FDATA[AXI_AW-1:2]: next_rdata = AXI_DW'(peek);
        REG_STATE[AXI_AW-1:2]: next_rdata = AXI_DW'(slot);
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && axi_rready_in) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= '0;
      w_lane  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= '0;
    end else if (ce_in) begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_lane  <= next_w_lane;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  assign retire_out     = retire;
  assign discard_out    = discard;
  assign port_latch_out = latch;
  assign work_out       = work;
  assign flags_out      = flags;
  assign axi_bvalid_out = bvalid;
  assign axi_bresp_out  = bresp;
  assign axi_rvalid_out = rvalid;
  assign axi_rresp_out  = rresp;
  assign axi_rdata_out  = rdata;
endmodule
`default_nettype wire

/* File: tb/abe_exec_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module abe_exec_sva (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_in,
  input wire logic                       ce_in,
  input wire abe_pkg::abe_instr_s        instr_in,
  input wire logic                       retire_out,
  input wire logic                       discard_out,
  input wire logic [abe_pkg::DATA_W-1:0] port_pins_in,
  input wire logic [abe_pkg::DATA_W-1:0] port_latch_out,
  input wire logic [abe_pkg::DATA_W-1:0] work_out,
  input wire abe_pkg::abe_flags_s        flags_out
);
  import abe_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic       take;
  logic       is_bit;
  logic [1:0] sub;
  logic [2:0] bn;
  logic [6:0] fa;
  logic [7:0] k;
  logic [8:0] sum_k;
  logic [8:0] sum_p;
  logic [4:0] nib;
  assign take = instr_in.valid && ce_in;
  assign is_bit = instr_in.word[13:12] == OPC_BIT_GRP;
  assign sub = instr_in.word[11:10];
  assign bn = instr_in.word[9:7];
  assign fa = instr_in.word[6:0];
  assign k = instr_in.word[7:0];
  assign sum_k = {1'b0, work_out} + {1'b0, k};
  assign sum_p = {1'b0, work_out} + {1'b0, port_pins_in};
  assign nib = {1'b0, work_out[3:0]} + {1'b0, k[3:0]};
  // pins must sit still long enough to clear the synchroniser
  sequence s_pins_steady;
    (ce_in && $stable(port_pins_in)) [*5];
  endsequence
  sequence s_skip_hit;
    s_pins_steady ##0 (take && is_bit && sub[1] && fa == PORT_ADDR && port_pins_in[bn] == sub[0]);
  endsequence
  sequence s_skip_miss;
    s_pins_steady ##0 (take && is_bit && sub[1] && fa == PORT_ADDR && port_pins_in[bn] != sub[0]);
  endsequence
  property p_add_lit;
    take && instr_in.word[13:9] == OPC_ADD_LIT |=> discard_out || (work_out == $past(sum_k[7:0])
      && flags_out.c == $past(sum_k[8]) && flags_out.z == (work_out == 8'h00));
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");
  property p_digit;
    take && instr_in.word[13:9] == OPC_ADD_LIT |=> discard_out || flags_out.dc == $past(nib[4]);
  endproperty
  a_digit: assert property (p_digit) else $error("digit carry wrong");
  property p_and_lit;
    take && instr_in.word[13:8] == OPC_AND_LIT |=> discard_out || (work_out == $past(work_out & k)
      && flags_out.z == (work_out == 8'h00) && $stable(flags_out.c) && $stable(flags_out.dc));
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal result wrong");
  property p_bit_flags;
    take && is_bit |=> $stable(flags_out);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op touched flags");
  property p_bit_port;
    s_pins_steady ##0 (take && is_bit && !sub[1] && fa == PORT_ADDR) |=> discard_out ||
      port_latch_out == $past(sub[0] ? port_pins_in | (8'h01 << bn) : port_pins_in & ~(8'h01 << bn));
  endproperty
  a_bit_port: assert property (p_bit_port) else $error("port bit op ignored pins");
  property p_file_dest;
    s_pins_steady ##0 (take && instr_in.word[13:8] == OPC_ADD_FILE && fa == PORT_ADDR) |=>
      discard_out || ($past(instr_in.word[D_POS]) ? (port_latch_out == $past(sum_p[7:0])
      && $stable(work_out)) : work_out == $past(sum_p[7:0]));
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("wrong destination");
  property p_skip_hit;
    s_skip_hit ##1 (take && retire_out) |=> discard_out;
  endproperty
  a_skip_hit: assert property (p_skip_hit) else $error("skip did not discard");
  property p_skip_miss;
    s_skip_miss ##1 (take && retire_out) |=> retire_out;
  endproperty
  a_skip_miss: assert property (p_skip_miss) else $error("false skip taken");
endmodule
bind abe_exec_unit abe_exec_sva i_sva (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .instr_in(instr_in),
  .retire_out(retire_out), .discard_out(discard_out), .port_pins_in(port_pins_in),
  .port_latch_out(port_latch_out), .work_out(work_out), .flags_out(flags_out));
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import abe_pkg::*;
  logic        clk, rst, ret, disc, awr, wr_rdy, bv, arr, rv, awv, wv, brd, arv, rrd, ce, ird;
  logic [3:0]  strb;
  abe_instr_s  instr;
  abe_flags_s  flags;
  logic [7:0]  pins, latch, work;
  logic [5:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  brsp, rrsp;
  int          n_fail, n_checks;
  localparam logic [5:0] ADDL = {OPC_ADD_LIT, 1'b0};
  abe_exec_unit i_dut (.clk_sys_in(clk), .rst_in(rst), .ce_in(ce), .instr_in(instr),
    .instr_ready_out(ird), .retire_out(ret), .discard_out(disc), .port_pins_in(pins),
    .port_latch_out(latch), .work_out(work), .flags_out(flags), .axi_awaddr_in(awa),
    .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_wdata_in(wd), .axi_wstrb_in(strb),
    .axi_wvalid_in(wv), .axi_wready_out(wr_rdy), .axi_bresp_out(brsp), .axi_bvalid_out(bv),
    .axi_bready_in(brd), .axi_araddr_in(ara), .axi_arvalid_in(arv), .axi_arready_out(arr),
    .axi_rdata_out(rdat), .axi_rresp_out(rrsp), .axi_rvalid_out(rv), .axi_rready_in(rrd));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task end_sim;
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [13:0] op(input logic [5:0] o, input logic [7:0] v);
    return {o, v};
  endfunction
  function logic [13:0] bo(input logic [1:0] o, input logic [2:0] b, input logic [6:0] f);
    return {OPC_BIT_GRP, o, b, f};
  endfunction
  // handshakes are sampled at the falling edge, where combinational readies have settled
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    @(posedge clk);
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; brd <= 1;
    repeat (40) begin
      @(negedge clk);
      ha = awv && awr; hw = wv && wr_rdy; hb = bv;
      if (hb) cmp(brsp, er);
      @(posedge clk);
      if (ha) awv <= 0;
      if (hw) wv <= 0;
      if (hb) begin
        brd <= 0;
        return;
      end
    end
    n_fail++;
    end_sim;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ha, hb;
    @(posedge clk);
    ara <= a; arv <= 1; rrd <= 1;
    repeat (40) begin
      @(negedge clk);
      ha = arv && arr; hb = rv;
      if (hb) begin
        cmp(rdat, {24'h0, d});
        cmp(rrsp, er);
      end
      @(posedge clk);
      if (ha) arv <= 0;
      if (hb) begin
        rrd <= 0;
        return;
      end
    end
    n_fail++;
    end_sim;
  endtask
  task automatic slot(input logic s);
    @(negedge clk);
    cmp(disc, s);
    cmp(ret, !s);
  endtask
  // back to back, one instruction taken per edge
  task automatic run(input logic [13:0] w[$], input logic s[$]);
    logic sv;
    @(posedge clk);
    foreach (w[i]) begin
      instr <= {1'b1, w[i]};
      @(posedge clk);
      sv = s[i];
      fork
        slot(sv);
      join_none
    end
    instr <= '0;
    // results land at the launching edge, so callers look half a cycle later
    @(negedge clk);
  endtask
  task t_lit;
    wr(REG_FLAGS, 8'h00, RESP_OKAY);
    wr(REG_WORK, 8'hf1, RESP_OKAY);
    run('{op(ADDL, 8'h0f)}, '{0});
    cmp(work, 8'h00);
    cmp(flags, 3'h7);
    rd(REG_FLAGS, 8'h07, RESP_OKAY);
    wr(REG_WORK, 8'h08, RESP_OKAY);
    run('{op(ADDL, 8'hff)}, '{0});
    cmp(work, 8'h07);
    rd(REG_FLAGS, 8'h03, RESP_OKAY);
    wr(REG_WORK, 8'hf0, RESP_OKAY);
    run('{op(OPC_AND_LIT, 8'h0f)}, '{0});
    cmp(work, 8'h00);
    rd(REG_FLAGS, 8'h07, RESP_OKAY);
  endtask
  task t_file;
    wr(REG_FSEL, 8'h20, RESP_OKAY);
    wr(REG_FDATA, 8'h3c, RESP_OKAY);
    wr(REG_WORK, 8'h05, RESP_OKAY);
    run('{op(OPC_ADD_FILE, 8'ha0), op(OPC_ADD_FILE, 8'h20), op(OPC_AND_FILE, 8'ha0)},
        '{0, 0, 0});
    cmp(work, 8'h46);
    rd(REG_FDATA, 8'h40, RESP_OKAY);
    rd(REG_FLAGS, 8'h00, RESP_OKAY);
    wr(REG_FLAGS, 8'h07, RESP_OKAY);
    run('{bo(BITOP_SET, 3'h7, 7'h20), bo(BITOP_CLEAR, 3'h6, 7'h20)}, '{0, 0});
    rd(REG_FDATA, 8'h80, RESP_OKAY);
    rd(REG_FLAGS, 8'h07, RESP_OKAY);
  endtask
  task t_skip;
    wr(REG_WORK, 8'h00, RESP_OKAY);
    run('{bo(BITOP_SKIP_ONE, 3'h7, 7'h20), op(ADDL, 8'h01), op(ADDL, 8'h02),
          bo(BITOP_SKIP_ZERO, 3'h0, 7'h20), op(ADDL, 8'h04), bo(BITOP_SKIP_ONE, 3'h0, 7'h20),
          op(ADDL, 8'h08), bo(BITOP_SKIP_ZERO, 3'h7, 7'h20), op(ADDL, 8'h10)},
        '{0, 1, 0, 0, 1, 0, 0, 0, 0});
    cmp(work, 8'h1a);
    rd(REG_STATE, 8'h00, RESP_OKAY);
    rd(6'h14, 8'h00, RESP_SLVERR);
  endtask
  task t_port;
    @(posedge clk);
    pins <= 8'ha5;
    wr(REG_WORK, 8'h10, RESP_OKAY);
    repeat (4) @(posedge clk);
    run('{bo(BITOP_SET, 3'h1, PORT_ADDR)}, '{0});
    cmp(latch, 8'ha7);
    run('{bo(BITOP_SKIP_ZERO, 3'h0, PORT_ADDR), bo(BITOP_CLEAR, 3'h0, PORT_ADDR),
          bo(BITOP_SKIP_ONE, 3'h0, PORT_ADDR), op(ADDL, 8'h01), op(OPC_ADD_FILE, 8'h86)},
        '{0, 0, 0, 1, 0});
    cmp(latch, 8'hb5);
    cmp(work, 8'h10);
  endtask
  // enable low must hold off an offered instruction; a write without lane 0 is dropped
  task t_hold;
    wr(REG_WORK, 8'h01, RESP_OKAY);
    @(posedge clk);
    ce <= 0;
    instr <= {1'b1, op(ADDL, 8'h01)};
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(ird, 1'b0);
    cmp(ret, 1'b0);
    cmp(work, 8'h01);
    @(posedge clk);
    ce <= 1;
    instr <= '0;
    strb <= 4'h0;
    @(negedge clk);
    cmp(ird, 1'b1);
    cmp(work, 8'h01);
    wr(REG_WORK, 8'hee, RESP_OKAY);
    strb <= 4'h1;
    wr(6'h14, 8'h00, RESP_SLVERR);
    rd(REG_WORK, 8'h01, RESP_OKAY);
  endtask
  initial begin
    rst = 1; instr = '0; pins = 0; awa = 0; ara = 0; wd = 0;
    ce = 1;
    strb = 4'h1;
    awv = 0; wv = 0; brd = 0; arv = 0; rrd = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    t_lit;
    t_file;
    t_skip;
    t_port;
    t_hold;
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule
`default_nettype wire
